// File: frraw_pkg.sv
package frraw_pkg;

	// Array and bus geometry
	localparam int DEPTH_DEF = 2048;
	localparam int DATA_W    = 18;
	localparam int NARROW_W  = 9;
	localparam int AXI_AW    = 8;
	localparam int AXI_DW    = 32;
	localparam int STRB_W    = AXI_DW / 8;

	// Register byte addresses
	localparam logic [AXI_AW-1:0] ADDR_STATUS = 8'h00;
	localparam logic [AXI_AW-1:0] ADDR_OFFSET = 8'h04;
	localparam logic [AXI_AW-1:0] ADDR_LEAD   = 8'h08;

	// Offset register layout and reset value
	localparam int EOFF_LSB   = 0;
	localparam int EOFF_W     = 15;
	localparam int FOFF_LSB   = 16;
	localparam int FOFF_W     = 15;
	localparam int METHOD_BIT = 31;
	localparam logic [AXI_DW-1:0] OFFSET_RST = 32'h0040_0040;

	// Least write lead at mark, in words
	localparam logic [AXI_DW-1:0] LEAD_RST = 32'h0000_0010;

	// Status register layout
	localparam int ST_FALL_THROUGH_MODE    = 0;
	localparam int ST_ASYNC   = 1;
	localparam int ST_MARKED  = 2;
	localparam int ST_SETUP   = 3;
	localparam int ST_LEADLOW = 4;
	localparam int ST_FULL    = 5;
	localparam int ST_EMPTY   = 6;
	localparam int ST_CFG_LSB = 8;
	localparam int CFG_W      = 6;
	localparam int ST_CNT_LSB = 16;
	localparam int ST_CNT_W   = 16;

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Retransmit sequencing
	typedef enum logic [1:0] {
		RT_IDLE,
		RT_MARKED,
		RT_SETUP
	} frraw_rt_t;

endpackage

// File: frraw_fifo_ctrl.sv
// Function
// - Standard mode: read edge with mark high, empty flag high marks output word.
// - Retransmit mode ends on read edge with mark low.
// - Marked mode, read edge with request low rewinds read pointer to mark.
// - Standard mode: empty flag low during setup, high after; reads need enable.
// - Fall-through mode: read edge with mark high, ready low marks output word.
// - Fall-through: ready high during setup; after release marked word loads itself.
// - After fall-through retransmit, later words need read enable low.
// - With mark set, write pointer never passes the marked location.
// - Each new mark replaces the previous one.
// - Master reset clears pointers, output register; sets flag reset levels.
// - Master reset picks standard or fall-through mode and its flag levels.
// - Configuration inputs captured only during master reset.
// - Partial reset clears pointers, output register; sets flag reset levels.
// - Partial reset keeps mode and sets that mode's flag levels.
// - Partial reset keeps flag offsets and programming method.
// - Async write select low at master reset: write clock is a strobe.
// - Async write port: full flag follows both writes and reads.
// - Data input 18 bits wide; narrow setting uses low 9 bits.
// - Standard mode: empty flag low while request low, high after release.
//
// Chosen here: the register offsets and the AXI4-Lite slave port.
module frraw_fifo_ctrl #(
	parameter int DEPTH = frraw_pkg::DEPTH_DEF,
	parameter int DW    = frraw_pkg::DATA_W
) (
	// System
	input  wire logic                         clk_i,
	input  wire logic                         rst_n_i,
	// FIFO control pins
	input  wire logic                         write_clk_i,
	input  wire logic                         read_clk_i,
	input  wire logic                         master_reset_n_i,
	input  wire logic                         partial_reset_n_i,
	input  wire logic                         write_enable_n_i,
	input  wire logic                         read_enable_n_i,
	input  wire logic                         mark_i,
	input  wire logic                         retransmit_request_n_i,
	// Configuration straps
	input  wire logic                         write_port_async_select_n_i,
	input  wire logic                         fall_through_select_serial_in_i,
	input  wire logic                         output_width_select_i,
	input  wire logic                         input_width_select_i,
	input  wire logic                         byte_order_select_i,
	input  wire logic                         read_mode_select_i,
	input  wire logic                         flag_timing_mode_i,
	input  wire logic                         parity_select_i,
	// Data
	input  wire logic [DW-1:0]                data_in_bus_i,
	output logic      [DW-1:0]                data_out_o,
	// Flags
	output logic                              empty_flag_n_o,
	output logic                              output_ready_n_o,
	output logic                              full_flag_n_o,
	output logic                              input_ready_n_o,
	output logic                              prog_almost_empty_flag_n_o,
	output logic                              prog_almost_full_flag_n_o,
	output logic                              half_full_flag_n_o,
	// AXI4-Lite slave
	input  wire logic [frraw_pkg::AXI_AW-1:0] s_axi_awaddr_i,
	input  wire logic                         s_axi_awvalid_i,
	output logic                              s_axi_awready_o,
	input  wire logic [frraw_pkg::AXI_DW-1:0] s_axi_wdata_i,
	input  wire logic [frraw_pkg::STRB_W-1:0] s_axi_wstrb_i,
	input  wire logic                         s_axi_wvalid_i,
	output logic                              s_axi_wready_o,
	output logic      [1:0]                   s_axi_bresp_o,
	output logic                              s_axi_bvalid_o,
	input  wire logic                         s_axi_bready_i,
	input  wire logic [frraw_pkg::AXI_AW-1:0] s_axi_araddr_i,
	input  wire logic                         s_axi_arvalid_i,
	output logic                              s_axi_arready_o,
	output logic      [frraw_pkg::AXI_DW-1:0] s_axi_rdata_o,
	output logic      [1:0]                   s_axi_rresp_o,
	output logic                              s_axi_rvalid_o,
	input  wire logic                         s_axi_rready_i
);

	localparam int PW   = $clog2(DEPTH) + 1;
	localparam int NPIN = 16 + DW;
	localparam logic [PW-1:0] DEPTH_P  = PW'(DEPTH);
	localparam logic [PW-1:0] HALF_P   = PW'(DEPTH / 2);
	localparam logic [PW-1:0] PTR_ONE  = PW'(32'h1);
	localparam logic [DW-1:0] NARROW_M = DW'((32'h1 << frraw_pkg::NARROW_W) - 32'h1);

	// Synchronised pins
	logic [NPIN-1:0] pin_a_r;
	logic [NPIN-1:0] pin_b_r;
	logic            s_wclk, s_rclk, s_mrs_n, s_prs_n, s_wen_n, s_ren_n;
	logic            s_mark, s_rt_n, s_async_n, s_fall_through_mode;
	logic [5:0]      s_cfg;
	logic [DW-1:0]   s_data;
	logic            wclk_d_r, rclk_d_r;

	// Captured mode
	logic                        fall_through_mode_r;
	logic                        async_wr_r;
	logic                        narrow_r;
	logic [frraw_pkg::CFG_W-1:0] cfg_r;

	// Array and pointers
	logic [DW-1:0]        mem [DEPTH];
	logic [PW-1:0]        wr_ptr_r, rd_ptr_r, mark_ptr_r;
	logic [DW-1:0]        out_r;
	logic                 valid_r;
	frraw_pkg::frraw_rt_t rt_st_r;

	// Flag registers
	logic ef_r, or_n_r, ff_r, ir_n_r, pae_n_r, paf_n_r, hf_n_r, lead_low_r;

	// Software registers
	logic [frraw_pkg::AXI_DW-1:0] offs_r, lead_r;

	// Bus slave state
	logic                         awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic                         aw_got_r, w_got_r;
	logic [1:0]                   bresp_r, rresp_r;
	logic [frraw_pkg::AXI_AW-1:0] waddr_r;
	logic [frraw_pkg::AXI_DW-1:0] wdata_r, rdata_r, status_c, rd_word_c;
	logic [frraw_pkg::STRB_W-1:0] wstrb_r;

	// Combinational terms
	logic          mrs_c, clr_c, wr_edge_c, rd_edge_c;
	logic [PW-1:0] count_c, guard_c;
	logic          empty_c, full_c, wr_go_c, rt_busy_c, mark_ok_c, mark_enter_c;
	logic          rt_start_c, rt_done_c, rd_std_c, ld_fall_through_mode_c, drain_c, wr_fire_c;
	logic [DW-1:0] din_c;
	logic [PW-1:0] eoff_c, foff_c;

	// Register address is mapped
	function automatic logic reg_hit(input logic [frraw_pkg::AXI_AW-1:0] a);
		reg_hit = (a == frraw_pkg::ADDR_STATUS) || (a == frraw_pkg::ADDR_OFFSET) ||
			(a == frraw_pkg::ADDR_LEAD);
	endfunction

	// Byte-lane merge of a register write
	function automatic logic [frraw_pkg::AXI_DW-1:0] merge(
		input logic [frraw_pkg::AXI_DW-1:0] old_v,
		input logic [frraw_pkg::AXI_DW-1:0] new_v,
		input logic [frraw_pkg::STRB_W-1:0] strb
	);
		merge = old_v;
		for (int b = 0; b < frraw_pkg::STRB_W; b++) begin
			if (strb[b]) begin
				merge[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
	endfunction

	// Two-stage synchroniser for every pin
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_a_r <= '0;
			pin_b_r <= '0;
		end else begin
			pin_a_r <= {write_clk_i, read_clk_i, master_reset_n_i, partial_reset_n_i,
				write_enable_n_i, read_enable_n_i, mark_i, retransmit_request_n_i,
				write_port_async_select_n_i, fall_through_select_serial_in_i,
				output_width_select_i, input_width_select_i, byte_order_select_i,
				read_mode_select_i, flag_timing_mode_i, parity_select_i, data_in_bus_i};
			pin_b_r <= pin_a_r;
		end
	end

	assign {s_wclk, s_rclk, s_mrs_n, s_prs_n, s_wen_n, s_ren_n, s_mark, s_rt_n,
		s_async_n, s_fall_through_mode, s_cfg, s_data} = pin_b_r;

	// Clock edge finders
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wclk_d_r <= 1'b0;
			rclk_d_r <= 1'b0;
		end else begin
			wclk_d_r <= s_wclk;
			rclk_d_r <= s_rclk;
		end
	end

	// Resets, edges and fill level
	assign mrs_c     = ~s_mrs_n;
	assign clr_c     = mrs_c | ~s_prs_n;
	assign wr_edge_c = s_wclk & ~wclk_d_r;
	assign rd_edge_c = s_rclk & ~rclk_d_r;
	assign count_c   = wr_ptr_r - rd_ptr_r;
	assign guard_c   = wr_ptr_r - mark_ptr_r;
	assign empty_c   = (count_c == '0);
	assign rt_busy_c = (rt_st_r == frraw_pkg::RT_SETUP);
	assign eoff_c    = PW'(offs_r[frraw_pkg::EOFF_LSB +: frraw_pkg::EOFF_W]);
	assign foff_c    = PW'(offs_r[frraw_pkg::FOFF_LSB +: frraw_pkg::FOFF_W]);

	// Full also when the next write would hit the marked word
	assign full_c = (count_c == DEPTH_P) ||
		((rt_st_r != frraw_pkg::RT_IDLE) && (guard_c == DEPTH_P));

	// Write strobe ignores enable in async mode
	assign wr_go_c = wr_edge_c & (async_wr_r | ~s_wen_n) & ~full_c & ~clr_c;
	assign din_c   = narrow_r ? (s_data & NARROW_M) : s_data;

	// Retransmit decisions on a read edge
	assign mark_ok_c    = fall_through_mode_r ? valid_r : ef_r;
	assign mark_enter_c = (rt_st_r == frraw_pkg::RT_IDLE) & s_mark & mark_ok_c;
	assign rt_start_c   = (rt_st_r == frraw_pkg::RT_MARKED) & s_mark & ~s_rt_n;
	assign rt_done_c    = rt_busy_c & s_mark & s_rt_n;
	assign rd_std_c     = ~fall_through_mode_r & ~s_ren_n & ~empty_c & ~rt_busy_c;
	assign ld_fall_through_mode_c    = fall_through_mode_r & ~empty_c & ~rt_busy_c & (~valid_r | ~s_ren_n);
	assign drain_c      = fall_through_mode_r & valid_r & ~s_ren_n & empty_c;

	// Mode and configuration capture
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fall_through_mode_r     <= 1'b0;
			async_wr_r <= 1'b0;
			narrow_r   <= 1'b0;
			cfg_r      <= '0;
		end else if (mrs_c) begin
			fall_through_mode_r     <= s_fall_through_mode;
			async_wr_r <= ~s_async_n;
			narrow_r   <= s_cfg[4];
			cfg_r      <= s_cfg;
		end
	end

	// Write pointer
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr_r <= '0;
		end else if (clr_c) begin
			wr_ptr_r <= '0;
		end else if (wr_go_c) begin
			wr_ptr_r <= wr_ptr_r + PTR_ONE;
		end
	end

	// Array write port
	always_ff @(posedge clk_i) begin
		if (wr_go_c) begin
			mem[wr_ptr_r[PW-2:0]] <= din_c;
		end
	end

	// Retransmit sequencing
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rt_st_r    <= frraw_pkg::RT_IDLE;
			mark_ptr_r <= '0;
		end else if (clr_c) begin
			rt_st_r    <= frraw_pkg::RT_IDLE;
			mark_ptr_r <= '0;
		end else if (rd_edge_c) begin
			unique case (rt_st_r)
				frraw_pkg::RT_IDLE: begin
					if (mark_enter_c) begin
						rt_st_r    <= frraw_pkg::RT_MARKED;
						mark_ptr_r <= rd_ptr_r - PTR_ONE;
					end
				end
				frraw_pkg::RT_MARKED: begin
					if (!s_mark) begin
						rt_st_r <= frraw_pkg::RT_IDLE;
					end else if (!s_rt_n) begin
						rt_st_r <= frraw_pkg::RT_SETUP;
					end
				end
				frraw_pkg::RT_SETUP: begin
					if (!s_mark) begin
						rt_st_r <= frraw_pkg::RT_IDLE;
					end else if (s_rt_n) begin
						rt_st_r <= frraw_pkg::RT_MARKED;
					end
				end
			endcase
		end
	end

	// Read pointer and output register
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_ptr_r <= '0;
			out_r    <= '0;
			valid_r  <= 1'b0;
		end else if (clr_c) begin
			rd_ptr_r <= '0;
			out_r    <= '0;
			valid_r  <= 1'b0;
		end else if (rd_edge_c) begin
			if (rt_start_c) begin
				rd_ptr_r <= mark_ptr_r;
				valid_r  <= 1'b0;
			end else if (rt_done_c && fall_through_mode_r) begin
				out_r    <= mem[mark_ptr_r[PW-2:0]];
				rd_ptr_r <= mark_ptr_r + PTR_ONE;
				valid_r  <= 1'b1;
			end else if (rd_std_c || ld_fall_through_mode_c) begin
				out_r    <= mem[rd_ptr_r[PW-2:0]];
				rd_ptr_r <= rd_ptr_r + PTR_ONE;
				valid_r  <= fall_through_mode_r;
			end else if (drain_c) begin
				valid_r  <= 1'b0;
			end
		end
	end

	// Status flags, refreshed every cycle from both sides
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ef_r    <= 1'b0;
			or_n_r  <= 1'b1;
			ff_r    <= 1'b1;
			ir_n_r  <= 1'b0;
			pae_n_r <= 1'b0;
			paf_n_r <= 1'b1;
			hf_n_r  <= 1'b1;
		end else if (clr_c) begin
			ef_r    <= 1'b0;
			or_n_r  <= 1'b1;
			ff_r    <= 1'b1;
			ir_n_r  <= 1'b0;
			pae_n_r <= 1'b0;
			paf_n_r <= 1'b1;
			hf_n_r  <= 1'b1;
		end else begin
			ef_r    <= ~empty_c & ~rt_busy_c;
			or_n_r  <= ~valid_r;
			ff_r    <= ~full_c;
			ir_n_r  <= full_c;
			pae_n_r <= (count_c > eoff_c);
			paf_n_r <= (count_c < (DEPTH_P - foff_c));
			hf_n_r  <= (count_c <= HALF_P);
		end
	end

	// Writer lead check when a mark is taken
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lead_low_r <= 1'b0;
		end else if (clr_c) begin
			lead_low_r <= 1'b0;
		end else if (rd_edge_c && mark_enter_c) begin
			lead_low_r <= (32'(count_c) < lead_r);
		end
	end

	// Offset and lead registers; partial reset leaves them alone
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			offs_r <= frraw_pkg::OFFSET_RST;
			lead_r <= frraw_pkg::LEAD_RST;
		end else begin
			if (mrs_c) begin
				offs_r <= frraw_pkg::OFFSET_RST;
			end else if (wr_fire_c && waddr_r == frraw_pkg::ADDR_OFFSET) begin
				offs_r <= merge(offs_r, wdata_r, wstrb_r);
			end
			if (wr_fire_c && waddr_r == frraw_pkg::ADDR_LEAD) begin
				lead_r <= merge(lead_r, wdata_r, wstrb_r);
			end
		end
	end

	// Bus write channels
	assign wr_fire_c = aw_got_r & w_got_r & ~bvalid_r;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			aw_got_r  <= 1'b0;
			w_got_r   <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= frraw_pkg::RESP_OKAY;
			waddr_r   <= '0;
			wdata_r   <= '0;
			wstrb_r   <= '0;
		end else begin
			if (s_axi_awvalid_i && awready_r) begin
				aw_got_r  <= 1'b1;
				awready_r <= 1'b0;
				waddr_r   <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && wready_r) begin
				w_got_r  <= 1'b1;
				wready_r <= 1'b0;
				wdata_r  <= s_axi_wdata_i;
				wstrb_r  <= s_axi_wstrb_i;
			end
			if (wr_fire_c) begin
				aw_got_r <= 1'b0;
				w_got_r  <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r  <= reg_hit(waddr_r) ? frraw_pkg::RESP_OKAY : frraw_pkg::RESP_SLVERR;
			end
			if (bvalid_r && s_axi_bready_i) begin
				bvalid_r  <= 1'b0;
				awready_r <= 1'b1;
				wready_r  <= 1'b1;
			end
		end
	end

	// Status word assembly
	always_comb begin
		status_c = '0;
		status_c[frraw_pkg::ST_FALL_THROUGH_MODE]    = fall_through_mode_r;
		status_c[frraw_pkg::ST_ASYNC]   = async_wr_r;
		status_c[frraw_pkg::ST_MARKED]  = (rt_st_r != frraw_pkg::RT_IDLE);
		status_c[frraw_pkg::ST_SETUP]   = rt_busy_c;
		status_c[frraw_pkg::ST_LEADLOW] = lead_low_r;
		status_c[frraw_pkg::ST_FULL]    = full_c;
		status_c[frraw_pkg::ST_EMPTY]   = empty_c;
		status_c[frraw_pkg::ST_CFG_LSB +: frraw_pkg::CFG_W] = cfg_r;
		status_c[frraw_pkg::ST_CNT_LSB +: frraw_pkg::ST_CNT_W] =
			frraw_pkg::ST_CNT_W'(count_c);
	end

	// Read data select
	always_comb begin
		unique case (s_axi_araddr_i)
			frraw_pkg::ADDR_STATUS: rd_word_c = status_c;
			frraw_pkg::ADDR_OFFSET: rd_word_c = offs_r;
			frraw_pkg::ADDR_LEAD:   rd_word_c = lead_r;
			default:                rd_word_c = '0;
		endcase
	end

	// Bus read channels
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			arready_r <= 1'b1;
			rvalid_r  <= 1'b0;
			rdata_r   <= '0;
			rresp_r   <= frraw_pkg::RESP_OKAY;
		end else begin
			if (s_axi_arvalid_i && arready_r) begin
				arready_r <= 1'b0;
				rvalid_r  <= 1'b1;
				rdata_r   <= rd_word_c;
				rresp_r   <= reg_hit(s_axi_araddr_i) ? frraw_pkg::RESP_OKAY :
					frraw_pkg::RESP_SLVERR;
			end
			if (rvalid_r && s_axi_rready_i) begin
				rvalid_r  <= 1'b0;
				arready_r <= 1'b1;
			end
		end
	end

	// Outputs from registers
	assign data_out_o                 = out_r;
	assign empty_flag_n_o             = ef_r;
	assign output_ready_n_o           = or_n_r;
	assign full_flag_n_o              = ff_r;
	assign input_ready_n_o            = ir_n_r;
	assign prog_almost_empty_flag_n_o = pae_n_r;
	assign prog_almost_full_flag_n_o  = paf_n_r;
	assign half_full_flag_n_o         = hf_n_r;
	assign s_axi_awready_o            = awready_r;
	assign s_axi_wready_o             = wready_r;
	assign s_axi_bvalid_o             = bvalid_r;
	assign s_axi_bresp_o              = bresp_r;
	assign s_axi_arready_o            = arready_r;
	assign s_axi_rvalid_o             = rvalid_r;
	assign s_axi_rdata_o              = rdata_r;
	assign s_axi_rresp_o              = rresp_r;

endmodule // frraw_fifo_ctrl

// File: frraw_monitor.sv
module frraw_monitor (
	// Clock, resets and mode strap
	input  wire logic        clk_i, rst_n_i, master_reset_n_i, partial_reset_n_i,
	input  wire logic        fall_through_select_serial_in_i,
	// Data and flags
	input  wire logic [17:0] data_out_o,
	input  wire logic        empty_flag_n_o, output_ready_n_o, full_flag_n_o, input_ready_n_o,
	input  wire logic        prog_almost_empty_flag_n_o, prog_almost_full_flag_n_o,
	input  wire logic        half_full_flag_n_o,
	// Bus handshakes
	input  wire logic        s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o,
	input  wire logic        s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o,
	input  wire logic        s_axi_rvalid_o, s_axi_rready_i
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	AST_MRS_FLAGS: assert property ((!master_reset_n_i)[*6] |->
		!prog_almost_empty_flag_n_o && prog_almost_full_flag_n_o && half_full_flag_n_o
		&& data_out_o == 18'h0) else $error("master reset left flags or data");
	AST_MRS_MODE: assert property ((!master_reset_n_i)[*6] |->
		(fall_through_select_serial_in_i ? (output_ready_n_o && !input_ready_n_o)
		: (!empty_flag_n_o && full_flag_n_o))) else $error("mode flags wrong in master reset");
	AST_PRS_FLAGS: assert property ((!partial_reset_n_i)[*6] |->
		!prog_almost_empty_flag_n_o && prog_almost_full_flag_n_o && half_full_flag_n_o
		&& data_out_o == 18'h0 && !empty_flag_n_o && full_flag_n_o && output_ready_n_o
		&& !input_ready_n_o) else $error("partial reset left flags or data");
	AST_B_LAT: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
		&& s_axi_wready_o |-> ##[2:3] s_axi_bvalid_o) else $error("write response late");
	AST_B_BUSY: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
		else $error("write accepted while response pending");
	AST_B_DROP: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
		else $error("write response repeated");
	AST_R_LAT: assert property (s_axi_arvalid_i && s_axi_arready_o |=>
		s_axi_rvalid_o && !s_axi_arready_o) else $error("read data not next cycle");
	AST_R_DROP: assert property (s_axi_rvalid_o && s_axi_rready_i |=>
		!s_axi_rvalid_o && s_axi_arready_o) else $error("read data repeated");
endmodule // frraw_monitor

// File: frraw_link_model.sv
module frraw_link_model (
	// Clock and write port mode
	input  wire logic        clk_i,
	input  wire logic        async_i,
	// Writer and reader pins
	output logic             write_clk_o, read_clk_o, write_enable_n_o, read_enable_n_o,
	output logic             mark_o, retransmit_request_n_o,
	output logic      [17:0] data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic wen_r;

	// Enable tied low for the strobe port
	assign write_enable_n_o = async_i ? 1'b0 : wen_r;

	// Link clocks stand still between frames
	initial begin
		{write_clk_o, read_clk_o, mark_o} = '0;
		{wen_r, read_enable_n_o, retransmit_request_n_o} = '1;
		data_o = '0;
	end

	// Half of a 48 ns link period
	task automatic half;
		repeat (6) @(posedge clk_i);
	endtask

	// One write frame; released data shows its inverse
	task automatic wr(input logic [17:0] d);
		@(posedge clk_i);
		wen_r <= 1'b0;
		data_o <= d;
		half();
		write_clk_o <= 1'b1;
		half();
		write_clk_o <= 1'b0;
		wen_r <= 1'b1;
		data_o <= ~d;
	endtask

	// One read frame; reads are disabled before a request drops
	task automatic rd(input logic ren, input logic mk, input logic rt);
		@(posedge clk_i);
		read_enable_n_o <= ren | ~rt;
		mark_o <= mk;
		half();
		retransmit_request_n_o <= rt;
		half();
		read_clk_o <= 1'b1;
		half();
		read_clk_o <= 1'b0;
	endtask
endmodule // frraw_link_model

// File: frraw_tb_top.sv
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
	$display("mismatch %s exp %h got %h", nm, e, g); end end
module frraw_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DEPTH = 16;
	logic        clk_i, rst_n_i, master_reset_n_i, partial_reset_n_i, write_clk_i, read_clk_i;
	logic        write_enable_n_i, read_enable_n_i, mark_i, retransmit_request_n_i;
	logic        write_port_async_select_n_i, fall_through_select_serial_in_i;
	logic        output_width_select_i, input_width_select_i, byte_order_select_i;
	logic        read_mode_select_i, flag_timing_mode_i, parity_select_i;
	logic [17:0] data_in_bus_i, data_out_o;
	logic        empty_flag_n_o, output_ready_n_o, full_flag_n_o, input_ready_n_o;
	logic        prog_almost_empty_flag_n_o, prog_almost_full_flag_n_o, half_full_flag_n_o;
	logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
	logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rdv;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, rrv;
	logic        s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
	logic        s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
	logic        s_axi_rvalid_o, s_axi_rready_i;
	int          miscompares, tests_run, i;

	// Block under test and its writer and reader
	frraw_fifo_ctrl #(.DEPTH(DEPTH)) frraw_fifo_ctrl_inst (.*, .s_axi_wstrb_i(4'hf));
	frraw_link_model frraw_link_model_inst (.clk_i, .async_i(!write_port_async_select_n_i),
		.write_clk_o(write_clk_i), .read_clk_o(read_clk_i), .write_enable_n_o(write_enable_n_i),
		.read_enable_n_o(read_enable_n_i), .mark_o(mark_i),
		.retransmit_request_n_o(retransmit_request_n_i), .data_o(data_in_bus_i));

	// 250 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	task automatic test_done;
		if (miscompares == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Exhausted wait counts as a mismatch
	task automatic limit(input int n);
		if (n >= 40) begin
			miscompares++;
			test_done();
		end
	endtask

	// Bus write, address and data offered together
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge clk_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
		for (n = 0; n < 40; n++) begin
			@(posedge clk_i);
			if (s_axi_awready_o)
				s_axi_awvalid_i <= 1'b0;
			if (s_axi_wready_o)
				s_axi_wvalid_i <= 1'b0;
			if (s_axi_bvalid_o)
				break;
		end
		s_axi_bready_i <= 1'b0;
		limit(n);
		`CHK("bresp", er, s_axi_bresp_o)
	endtask

	// Bus read into rdv and rrv
	task automatic axi_rd(input logic [7:0] a);
		int n;
		@(posedge clk_i);
		s_axi_araddr_i <= a;
		{s_axi_arvalid_i, s_axi_rready_i} <= 2'h3;
		for (n = 0; n < 40; n++) begin
			@(posedge clk_i);
			if (s_axi_arready_o)
				s_axi_arvalid_i <= 1'b0;
			if (s_axi_rvalid_o)
				break;
		end
		s_axi_rready_i <= 1'b0;
		rdv = s_axi_rdata_o;
		rrv = s_axi_rresp_o;
		limit(n);
	endtask

	// Link frames
	task automatic wr(input logic [17:0] d);
		frraw_link_model_inst.wr(d);
	endtask
	task automatic rd(input logic ren, input logic mk, input logic rt);
		frraw_link_model_inst.rd(ren, mk, rt);
	endtask
	function automatic logic [17:0] w(input int k);
		return 18'h2a500 + 18'(k);
	endfunction

	// Master reset with mode straps
	task automatic mrst(input logic fw, input logic an, input logic nw);
		@(posedge clk_i);
		fall_through_select_serial_in_i <= fw;
		write_port_async_select_n_i <= an;
		input_width_select_i <= nw;
		master_reset_n_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		master_reset_n_i <= 1'b1;
		repeat (8) @(posedge clk_i);
	endtask

	// Main sequence
	initial begin
		{s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, s_axi_awvalid_i, s_axi_wvalid_i} = '0;
		{s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i, rst_n_i, master_reset_n_i} = '0;
		{input_width_select_i, read_mode_select_i, parity_select_i} = '0;
		fall_through_select_serial_in_i = 1'b0;
		{partial_reset_n_i, write_port_async_select_n_i, output_width_select_i} = '1;
		{byte_order_select_i, flag_timing_mode_i} = '1;
		miscompares = 0;
		tests_run = 0;
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'b1;
		// Straps, register reset values, refusals
		mrst(1'b0, 1'b1, 1'b0);
		output_width_select_i <= 1'b0;
		axi_rd(8'h00);
		`CHK("status", 32'h0000_2a40, rdv)
		`CHK("ef", 1'b0, empty_flag_n_o)
		axi_rd(8'h04);
		`CHK("offset", 32'h0040_0040, rdv)
		axi_rd(8'h08);
		`CHK("lead", 32'h0000_0010, rdv)
		axi_rd(8'h0c);
		`CHK("rresp", 2'h2, rrv)
		axi_wr(8'h0c, 32'h1, 2'h2);
		axi_wr(8'h00, 32'hffff_ffff, 2'h0);
		axi_wr(8'h04, 32'h8003_0002, 2'h0);
		axi_wr(8'h08, 32'h4, 2'h0);
		// Standard mode mark and retransmit
		for (i = 0; i < 10; i++)
			wr(w(i));
		for (i = 0; i < 3; i++)
			rd(1'b0, 1'b0, 1'b1);
		rd(1'b1, 1'b1, 1'b1);
		axi_rd(8'h00);
		`CHK("status", 32'h0007_2a04, rdv)
		rd(1'b0, 1'b1, 1'b1);
		rd(1'b0, 1'b1, 1'b1);
		`CHK("q", w(4), data_out_o)
		rd(1'b1, 1'b1, 1'b0);
		`CHK("ef", 1'b0, empty_flag_n_o)
		rd(1'b1, 1'b1, 1'b0);
		`CHK("ef", 1'b0, empty_flag_n_o)
		rd(1'b1, 1'b1, 1'b1);
		`CHK("ef", 1'b1, empty_flag_n_o)
		`CHK("q", w(4), data_out_o)
		rd(1'b0, 1'b1, 1'b1);
		`CHK("q", w(2), data_out_o)
		rd(1'b0, 1'b1, 1'b1);
		rd(1'b1, 1'b0, 1'b1);
		axi_rd(8'h00);
		`CHK("status", 32'h0006_2a00, rdv)
		rd(1'b1, 1'b1, 1'b1);
		rd(1'b0, 1'b1, 1'b1);
		rd(1'b1, 1'b1, 1'b0);
		rd(1'b1, 1'b1, 1'b1);
		rd(1'b0, 1'b1, 1'b1);
		`CHK("q", w(3), data_out_o)
		// Writes stop at the marked slot
		for (i = 10; i < 19; i++)
			wr(w(i));
		wr(18'h3ffff);
		axi_rd(8'h00);
		`CHK("count", 16'h000f, rdv[31:16])
		rd(1'b1, 1'b1, 1'b0);
		rd(1'b1, 1'b1, 1'b1);
		rd(1'b0, 1'b1, 1'b1);
		`CHK("q", w(3), data_out_o)
		// Partial reset keeps mode and offsets
		@(posedge clk_i);
		partial_reset_n_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		partial_reset_n_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		axi_rd(8'h04);
		`CHK("offset", 32'h8003_0002, rdv)
		axi_rd(8'h00);
		`CHK("status", 32'h0000_2a40, rdv)
		// Fall-through retransmit
		mrst(1'b1, 1'b1, 1'b0);
		`CHK("or", 1'b1, output_ready_n_o)
		for (i = 0; i < 6; i++)
			wr(w(i));
		rd(1'b1, 1'b0, 1'b1);
		`CHK("or", 1'b0, output_ready_n_o)
		rd(1'b1, 1'b1, 1'b1);
		rd(1'b0, 1'b1, 1'b1);
		`CHK("q", w(1), data_out_o)
		rd(1'b1, 1'b1, 1'b0);
		`CHK("or", 1'b1, output_ready_n_o)
		rd(1'b1, 1'b1, 1'b1);
		`CHK("q", w(0), data_out_o)
		`CHK("or", 1'b0, output_ready_n_o)
		rd(1'b1, 1'b1, 1'b1);
		`CHK("q", w(0), data_out_o)
		rd(1'b0, 1'b1, 1'b1);
		`CHK("q", w(1), data_out_o)
		// Strobe write port, narrow input, fill to full
		mrst(1'b0, 1'b0, 1'b1);
		for (i = 0; i < DEPTH - 1; i++)
			wr(18'h3ff00 + 18'(i));
		`CHK("ff", 1'b1, full_flag_n_o)
		wr(18'h3ffff);
		`CHK("ff", 1'b0, full_flag_n_o)
		rd(1'b0, 1'b0, 1'b1);
		`CHK("q", 18'h00100, data_out_o)
		`CHK("ff", 1'b1, full_flag_n_o)
		axi_rd(8'h00);
		`CHK("async", 1'b1, rdv[1])
		test_done();
	end
endmodule // frraw_tb_top

bind frraw_fifo_ctrl frraw_monitor frraw_monitor_inst (.*);
